/* crre_core.sv */
`default_nettype none
// Operation
// - top five bits 11011 decode relative call, low 11 bits signed offset
// - relative call pushes PC plus 2 as new stack top
// - relative call then loads PC with PC plus 2 plus 2n
// - relative call is one word, two cycles, target from incremented PC
// - word 00FF is software reset, one cycle
// - software reset restores all master-clear reset values and flags
// - 0010/0011 decode interrupt return, bit 0 selects shadow restore
// - interrupt return pops stack into PC
// - interrupt return sets high or low global enable in pop phase
// - s=1 restores working, status, bank select from shadows
// - s=0 leaves working, status, bank select unchanged
// - 0Ckk decodes literal return loading k into working register
// - literal return loads PC from stack top, latches unchanged
// - push moves previous top one level down
module crre_core
    import crre_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // instruction fetch
    input wire logic [15:0] instrWord,
    input wire logic [crre_pkg::PC_W-1:0] fetchPc,
    // interrupt priority context
    input wire logic lowPriorityReturn,
    // shadow copies
    input wire logic [7:0] workingShadow,
    input wire logic [4:0] statusShadow,
    input wire logic [3:0] bankSelectShadow,
    // architectural state
    output logic [crre_pkg::PC_W-1:0] pcOut,
    output logic [7:0] workingReg,
    output logic [4:0] statusReg,
    output logic [3:0] bankSelectRegister,
    output logic highPriorityGlobalEnable,
    output logic lowPriorityGlobalEnable,
    output logic [crre_pkg::PC_W-1:0] stackTop,
    // timing
    output logic [1:0] phase,
    output logic refillCycle,
    output logic softResetPulse
);
    crre_stack_if stk ();
    crre_stack u_stack (.sys_clk(sys_clk), .rst(rst), .stk(stk));
    crre_phase_e phase_q, phase_d;
    logic [15:0] ir_q, ir_d;
    logic refill_q, refill_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [7:0] w_q, w_d, lit_q, lit_d;
    logic [4:0] st_q, st_d;
    logic [3:0] bsr_q, bsr_d;
    logic high_priority_global_enable_q, high_priority_global_enable_d, low_priority_global_enable_q, low_priority_global_enable_d, srst_q, srst_d;
    logic isCall, isSoftReset, isIret, isLret;
    logic [PC_W-1:0] offset2;
    // ----------------------------------------
    // decode
    // ----------------------------------------
    always_comb begin
        isCall = ir_q[15:11] == CALL_TOP;
        isSoftReset = ir_q == SOFT_RESET_WORD;
        isIret = ir_q[15:1] == IRET_TOP;
        isLret = ir_q[15:8] == LRET_TOP;
        offset2 = {{(PC_W-12){ir_q[10]}}, ir_q[10:0], 1'b0};
    end
    // ----------------------------------------
    // execute
    // ----------------------------------------
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            Q1: phase_d = Q2;
            Q2: phase_d = Q3;
            Q3: phase_d = Q4;
            Q4: phase_d = Q1;
        endcase
        ir_d = ir_q;
        refill_d = refill_q;
        pc_d = pc_q;
        w_d = w_q;
        lit_d = lit_q;
        st_d = st_q;
        bsr_d = bsr_q;
        high_priority_global_enable_d = high_priority_global_enable_q;
        low_priority_global_enable_d = low_priority_global_enable_q;
        srst_d = 1'b0;
        stk.push = 1'b0;
        stk.pop = 1'b0;
        stk.clear = 1'b0;
        stk.pushData = pc_q + PC_STEP;
        if (phase_q == Q4) begin
            ir_d = instrWord;
            pc_d = fetchPc;
            refill_d = 1'b0;
        end
        // the refill cycle only loads the next fetch at Q4; the word it holds is simply dropped
        if (!refill_q) begin
            if (phase_q == Q2 && isCall) begin
                stk.push = 1'b1;
            end
            if (phase_q == Q2 && isLret) begin
                lit_d = ir_q[7:0];
            end
            if (phase_q == Q4) begin
                if (isCall) begin
                    pc_d = pc_q + PC_STEP + offset2;
                    refill_d = 1'b1;
                end else if (isIret) begin
                    stk.pop = 1'b1;
                    pc_d = stk.top;
                    refill_d = 1'b1;
                    if (lowPriorityReturn) low_priority_global_enable_d = 1'b1;
                    else high_priority_global_enable_d = 1'b1;
                    if (ir_q[0]) begin
                        w_d = workingShadow;
                        st_d = statusShadow;
                        bsr_d = bankSelectShadow;
                    end
                end else if (isLret) begin
                    stk.pop = 1'b1;
                    pc_d = stk.top;
                    w_d = lit_q;
                    refill_d = 1'b1;
                end else if (isSoftReset) begin
                    // same values as rst; fetch restarts at reset vector
                    stk.clear = 1'b1;
                    pc_d = PC_RESET;
                    w_d = WREG_RESET;
                    st_d = STATUS_RESET;
                    bsr_d = BSR_RESET;
                    high_priority_global_enable_d = 1'b0;
                    low_priority_global_enable_d = 1'b0;
                    srst_d = 1'b1;
                    lit_d = 8'h00;
                    ir_d = 16'h0000;
                end
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_q <= Q1;
            ir_q <= 16'h0000;
            refill_q <= 1'b0;
            pc_q <= PC_RESET;
            w_q <= WREG_RESET;
            lit_q <= 8'h00;
            st_q <= STATUS_RESET;
            bsr_q <= BSR_RESET;
            high_priority_global_enable_q <= 1'b0;
            low_priority_global_enable_q <= 1'b0;
            srst_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            ir_q <= ir_d;
            refill_q <= refill_d;
            pc_q <= pc_d;
            w_q <= w_d;
            lit_q <= lit_d;
            st_q <= st_d;
            bsr_q <= bsr_d;
            high_priority_global_enable_q <= high_priority_global_enable_d;
            low_priority_global_enable_q <= low_priority_global_enable_d;
            srst_q <= srst_d;
        end
    end
    always_comb begin
        pcOut = pc_q;
        workingReg = w_q;
        statusReg = st_q;
        bankSelectRegister = bsr_q;
        highPriorityGlobalEnable = high_priority_global_enable_q;
        lowPriorityGlobalEnable = low_priority_global_enable_q;
        stackTop = stk.top;
        phase = phase_q;
        refillCycle = refill_q;
        softResetPulse = srst_q;
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_call_target: assert property (@(posedge sys_clk) disable iff (rst)
        phase_q == Q4 && !refill_q && isCall |=> pc_q == $past(pc_q) + PC_STEP
        + $past(offset2)) else $error("call target wrong");
    a_call_push: assert property (@(posedge sys_clk) disable iff (rst)
        phase_q == Q2 && !refill_q && isCall |=> ##1 stk.top == $past(pc_q, 2)
        + PC_STEP) else $error("return address wrong");
    a_call_refill: assert property (@(posedge sys_clk) disable iff (rst)
        phase_q == Q4 && !refill_q && isCall |=> refill_q [*4]) else
        $error("no refill cycle");
    a_refill_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        refill_q && phase_q != Q4 |=> $stable(w_q) && $stable(st_q) && $stable(bsr_q))
        else $error("refill cycle acted");
    a_soft_reset: assert property (@(posedge sys_clk) disable iff (rst)
        phase_q == Q4 && !refill_q && isSoftReset |=> pc_q == PC_RESET
        && w_q == WREG_RESET && !high_priority_global_enable_q && !low_priority_global_enable_q && srst_q) else
        $error("soft reset incomplete");
    a_soft_status: assert property (@(posedge sys_clk) disable iff (rst)
        srst_q |-> st_q == STATUS_RESET && bsr_q == BSR_RESET && !refill_q) else
        $error("soft reset flags wrong");
    a_iret_pop: assert property (@(posedge sys_clk) disable iff (rst)
        phase_q == Q4 && !refill_q && isIret |=> pc_q == $past(stk.top)) else
        $error("iret pc wrong");
    a_iret_enable: assert property (@(posedge sys_clk) disable iff (rst)
        phase_q == Q4 && !refill_q && isIret |=> ($past(lowPriorityReturn) ? low_priority_global_enable_q : high_priority_global_enable_q))
        else $error("iret enable missing");
    a_iret_shadow: assert property (@(posedge sys_clk) disable iff (rst)
        phase_q == Q4 && !refill_q && isIret && ir_q[0] |=> w_q == $past(workingShadow)
        && st_q == $past(statusShadow) && bsr_q == $past(bankSelectShadow)) else
        $error("shadow restore wrong");
    a_iret_keep: assert property (@(posedge sys_clk) disable iff (rst)
        phase_q == Q4 && !refill_q && isIret && !ir_q[0] |=> $stable(w_q)
        && $stable(st_q) && $stable(bsr_q)) else $error("registers changed");
    a_lret_literal: assert property (@(posedge sys_clk) disable iff (rst)
        phase_q == Q2 && !refill_q && isLret |=> lit_q == $past(ir_q[7:0])) else
        $error("literal not read");
    a_soft_stack: assert property (@(posedge sys_clk) disable iff (rst)
        srst_q |-> stk.top == PC_RESET) else $error("stack not cleared");
    a_lret_write: assert property (@(posedge sys_clk) disable iff (rst)
        phase_q == Q4 && !refill_q && isLret |=> w_q == $past(ir_q[7:0])
        && pc_q == $past(stk.top)) else $error("literal return wrong");
endmodule
`default_nettype wire

/* crre_pkg.sv */
`default_nettype none
package crre_pkg;
    localparam int PC_W = 21;
    localparam int STK_DEPTH = 31;
    localparam int STK_PTR_W = 5;
    localparam logic [4:0] CALL_TOP = 5'h1B;
    localparam logic [15:0] SOFT_RESET_WORD = 16'h00FF;
    localparam logic [14:0] IRET_TOP = 15'h0008;
    localparam logic [7:0] LRET_TOP = 8'h0C;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [7:0] WREG_RESET = 8'h00;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    localparam logic [3:0] BSR_RESET = 4'h0;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    typedef enum logic [1:0] {Q1 = 2'b00, Q2 = 2'b01, Q3 = 2'b11, Q4 = 2'b10} crre_phase_e;
endpackage
`default_nettype wire

/* crre_stack_if.sv */
`default_nettype none
interface crre_stack_if;
    import crre_pkg::*;
    logic push;
    logic pop;
    logic clear;
    logic [PC_W-1:0] pushData;
    logic [PC_W-1:0] top;
    modport core (output push, output pop, output clear, output pushData, input top);
    modport stack (input push, input pop, input clear, input pushData, output top);
endinterface
`default_nettype wire

/* crre_stack.sv */
`default_nettype none
module crre_stack
    import crre_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // core side
    crre_stack_if.stack stk
);
    logic [PC_W-1:0] mem_q [STK_DEPTH];
    logic [PC_W-1:0] mem_d [STK_DEPTH];
    logic [PC_W-1:0] top_q;
    logic [PC_W-1:0] top_d;
    // ----------------------------------------
    // shift stack: entry 0 is the top
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < STK_DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (stk.clear) begin
            for (int i = 0; i < STK_DEPTH; i++) begin
                mem_d[i] = PC_RESET;
            end
        end else if (stk.push) begin
            mem_d[0] = stk.pushData;
            for (int i = 1; i < STK_DEPTH; i++) begin
                mem_d[i] = mem_q[i-1];
            end
        end else if (stk.pop) begin
            for (int i = 0; i < STK_DEPTH - 1; i++) begin
                mem_d[i] = mem_q[i+1];
            end
            mem_d[STK_DEPTH-1] = PC_RESET;
        end
        top_d = mem_d[0];
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < STK_DEPTH; i++) begin
                mem_q[i] <= PC_RESET;
            end
            top_q <= PC_RESET;
        end else begin
            mem_q <= mem_d;
            top_q <= top_d;
        end
    end
    assign stk.top = top_q;
    a_push_moves_down: assert property (@(posedge sys_clk) disable iff (rst)
        stk.push && !stk.clear |=> mem_q[1] == $past(mem_q[0])) else $error("push lost old top");
endmodule
`default_nettype wire

/* crre_prog_mem.sv */
`default_nettype none
module crre_prog_mem
(
    // clock
    input wire logic sys_clk,
    // core timing
    input wire logic [1:0] phase,
    // fetch bus
    output logic [15:0] instrWord,
    output logic [crre_pkg::PC_W-1:0] fetchPc
);
    timeunit 1ns;
    timeprecision 1ns;
    import crre_pkg::*;
    logic hold = 1'b0;
    initial begin
        instrWord = 16'h0000;
        fetchPc = 21'h000000;
    end
    // -------------------------------------------------------------------
    // idle fetch
    // -------------------------------------------------------------------
    // the address lines churn between fetches so a stale value never passes for a live one
    always @(negedge sys_clk) begin
        if (!hold) begin
            instrWord <= 16'h0000;
            fetchPc <= ~fetchPc;
        end
    end
    // -------------------------------------------------------------------
    // one fetched word, held until the q4 edge samples it
    // -------------------------------------------------------------------
    task automatic put(input logic [15:0] w, input logic [PC_W-1:0] a, output logic ok);
        int i;
        hold = 1'b1;
        @(negedge sys_clk);
        for (i = 0; i < 8 && phase !== Q4; i++) begin
            @(negedge sys_clk);
        end
        instrWord = w;
        fetchPc = a;
        @(posedge sys_clk);
        hold = 1'b0;
        ok = (i < 8);
    endtask
endmodule
`default_nettype wire

/* tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import crre_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] instrWord;
    logic [PC_W-1:0] fetchPc;
    logic lowPriorityReturn = 1'b0;
    logic [7:0] workingShadow = 8'h5A;
    logic [4:0] statusShadow = 5'h15;
    logic [3:0] bankSelectShadow = 4'hA;
    logic [PC_W-1:0] pcOut;
    logic [PC_W-1:0] stackTop;
    logic [7:0] workingReg;
    logic [4:0] statusReg;
    logic [3:0] bankSelectRegister;
    logic hiEn;
    logic loEn;
    logic [1:0] phase;
    logic refillCycle;
    logic softResetPulse;
    logic ok;
    int n_errors = 0;
    int comparisons = 0;
    int i;
    crre_core dut (.sys_clk(sys_clk), .rst(rst), .instrWord(instrWord), .fetchPc(fetchPc),
        .lowPriorityReturn(lowPriorityReturn), .workingShadow(workingShadow),
        .statusShadow(statusShadow), .bankSelectShadow(bankSelectShadow), .pcOut(pcOut),
        .workingReg(workingReg), .statusReg(statusReg), .bankSelectRegister(bankSelectRegister),
        .highPriorityGlobalEnable(hiEn), .lowPriorityGlobalEnable(loEn), .stackTop(stackTop),
        .phase(phase), .refillCycle(refillCycle), .softResetPulse(softResetPulse));
    crre_prog_mem pm (.sys_clk(sys_clk), .phase(phase), .instrWord(instrWord), .fetchPc(fetchPc));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic fetch(input logic [15:0] w, input logic [PC_W-1:0] a);
        pm.put(w, a, ok);
        if (ok !== 1'b1) begin
            n_errors++;
            close_out();
        end
    endtask
    // two-cycle op; a literal return offered during refill must be ignored
    task automatic exec(input logic [15:0] w, input logic [PC_W-1:0] a);
        fetch(w, a);
        fetch(16'h0CAA, 21'h1FFFFE);
        @(negedge sys_clk);
        chk(refillCycle, 1'b1);
    endtask
    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({pcOut, phase, hiEn, loEn}, 32'h0);
        rst = 1'b0;
        exec(16'hDBFF, 21'h000124);
        chk(stackTop, 21'h000126);
        chk(pcOut, 21'h000924);
        chk(workingReg, 8'h00);
        exec(16'hDC00, 21'h000926);
        chk(stackTop, 21'h000928);
        chk(pcOut, 21'h000128);
        exec(16'h0CFF, 21'h00012A);
        chk(pcOut, 21'h000928);
        chk(workingReg, 8'hFF);
        chk(stackTop, 21'h000126);
        exec(16'hD800, 21'h000200);
        chk(pcOut, 21'h000202);
        exec(16'h0010, 21'h000204);
        chk(pcOut, 21'h000202);
        chk({hiEn, loEn}, 2'b10);
        chk({workingReg, statusReg, bankSelectRegister}, 17'h1FE00);
        lowPriorityReturn = 1'b1;
        exec(16'h0011, 21'h000204);
        chk(pcOut, 21'h000126);
        chk({hiEn, loEn}, 2'b11);
        chk({workingReg, statusReg, bankSelectRegister}, 17'h0B55A);
        fetch(SOFT_RESET_WORD, 21'h000128);
        for (i = 0; i < 8 && softResetPulse !== 1'b1; i++) begin
            @(negedge sys_clk);
        end
        chk(i < 8, 1'b1);
        @(negedge sys_clk);
        chk({workingReg, statusReg, bankSelectRegister, hiEn, loEn}, 32'h0);
        chk({pcOut, stackTop}, 42'h0);
        // soft reset is one cycle, so the next call executes at the following fetch
        exec(16'hD801, 21'h000010);
        chk({pcOut, stackTop}, {21'h000014, 21'h000012});
        close_out();
    end
    initial begin
        #200000;
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
